// >>> bvr_remap.sv
// Boot vector address remap between processor local bus and boot flash
// How it works
// (R1) The boot flash is selected as an 8-bit device for addresses FFE0 0000h to FFFF FFFFh.
// (R2) After hard reset the processor fetches first from the reset vector FFF0 0100h.
// (R3) For the first two memory accesses after reset, address bit 20 is inverted.
// (R4) After those two accesses complete, address bit 20 passes unchanged until next reset.
// (R5) Multi-byte data is big-endian, most significant byte at the lowest address.
// (R6) Any hard reset (power-on, switch or JTAG) re-arms the remap sequence.
// (R7) A saturating access counter, cleared on reset, enables inversion while below two.
`timescale 1ns/1ps
`default_nettype none
`include "bvr_consts.svh"

module bvr_remap
	import bvr_pkg::*;
#(
	parameter int ADDR_W = `BVR_ADDR_W
)
(
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire bvr_req_t    cpu_req,
	input  wire logic [31:0] cpu_wdata,
	output var  bvr_out_t    mem_out,
	output var  logic [31:0] mem_wdata_be,
	output var  logic        remap_active,
	output var  logic [1:0]  access_count
);

	////////////////////////////////////////////////////////////////////////////////
	// Address decode, byte order and count helpers

	function automatic logic in_flash(input logic [31:0] a);
		in_flash = (a >= `BVR_FLASH_BASE) && (a <= `BVR_FLASH_LAST);    // [R1]
	endfunction

	function automatic logic [31:0] to_big_endian(input logic [31:0] w);
		to_big_endian = {w[7:0], w[15:8], w[23:16], w[31:24]};
	endfunction

	// Count as it will stand after this cycle, held at the limit
	function automatic logic [1:0] count_after(input logic [1:0] c, input logic step);
		if (step && (c < `BVR_REMAP_COUNT))
			count_after = c + 2'h1;
		else
			count_after = c;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Access counter

	logic [`BVR_CNT_W-1:0] count;
	logic                  below_limit;

	bvr_access_counter
	#(
		.CNT_W (`BVR_CNT_W),
		.LIMIT (`BVR_REMAP_COUNT)
	)
	u_counter
	(
		.clock       (clock),
		.reset_n     (reset_n),
		.done        (cpu_req.valid & cpu_req.done),
		.count       (count),
		.below_limit (below_limit)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Remap state

	bvr_state_t state_reg;
	bvr_state_t state_next;

	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			BVR_REMAP:
				if (!below_limit)
					state_next = BVR_PASS;                              // [R4]
			BVR_PASS:
				state_next = BVR_PASS;
			default:
				state_next = BVR_REMAP;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (!reset_n)
			state_reg <= BVR_REMAP;                                     // [R6]
		else
			state_reg <= state_next;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Address path, registered

	bvr_out_t    out_reg;
	bvr_out_t    out_next;
	logic [31:0] wdata_reg;
	logic [31:0] wdata_next;
	logic        active_reg;
	logic        active_next;
	logic [1:0]  cnt_reg;
	logic [1:0]  cnt_next;
	logic [31:0] addr_mod;
	logic [1:0]  count_ahead;

	always_comb
	begin
		addr_mod = cpu_req.addr;
		count_ahead = count_after(count, cpu_req.valid && cpu_req.done);
		// Reset vector FFF0 0100h lands on FFE0 0100h while armed
		if ((state_reg == BVR_REMAP) && below_limit)                    // [R2] [R3]
			addr_mod[`BVR_HALF_BIT] = ~cpu_req.addr[`BVR_HALF_BIT];
		out_next.valid     = cpu_req.valid;
		out_next.addr      = addr_mod;                                  // [R4]
		out_next.flash_sel = cpu_req.valid && in_flash(addr_mod);       // [R1]
		wdata_next         = to_big_endian(cpu_wdata);                  // [R5]
		// Status matches the count that the next access is judged by
		active_next        = (state_next == BVR_REMAP)
		                     && (count_ahead < `BVR_REMAP_COUNT);          // [R7]
		cnt_next           = count_ahead;                               // [R7]
	end

	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			out_reg    <= '0;
			wdata_reg  <= 32'h0000_0000;
			active_reg <= 1'b1;
			cnt_reg    <= `BVR_CNT_RESET;
		end
		else
		begin
			out_reg    <= out_next;
			wdata_reg  <= wdata_next;
			active_reg <= active_next;
			cnt_reg    <= cnt_next;
		end
	end

	assign mem_out      = out_reg;
	assign mem_wdata_be = wdata_reg;
	assign remap_active = active_reg;
	assign access_count = cnt_reg;

endmodule

`default_nettype wire

// >>> bvr_consts.svh
// Constants for the boot vector address remap block
`ifndef BVR_CONSTS_SVH
`define BVR_CONSTS_SVH

`define BVR_ADDR_W         32
`define BVR_FLASH_BASE     32'hFFE0_0000
`define BVR_FLASH_LAST     32'hFFFF_FFFF
`define BVR_RESET_VECTOR   32'hFFF0_0100
`define BVR_REMAP_VECTOR   32'hFFE0_0100
`define BVR_HALF_BIT       20
`define BVR_REMAP_COUNT    2
`define BVR_CNT_W          2
`define BVR_CNT_RESET      2'h0
`define BVR_FLASH_WIDTH    8

`endif

// >>> bvr_pkg.sv
// Types shared by the boot vector address remap block
`default_nettype none
package bvr_pkg;

	typedef struct packed
	{
		logic        valid;
		logic        done;
		logic [31:0] addr;
	} bvr_req_t;

	typedef struct packed
	{
		logic        valid;
		logic        flash_sel;
		logic [31:0] addr;
	} bvr_out_t;

	typedef enum logic [1:0]
	{
		BVR_REMAP = 2'b01,
		BVR_PASS  = 2'b10
	} bvr_state_t;

endpackage

`default_nettype wire

// >>> bvr_access_counter.sv
// Saturating counter of completed processor memory accesses
`timescale 1ns/1ps
`default_nettype none
`include "bvr_consts.svh"

module bvr_access_counter
#(
	parameter int CNT_W = `BVR_CNT_W,
	parameter int LIMIT = `BVR_REMAP_COUNT
)
(
	input  wire logic             clock,
	input  wire logic             reset_n,
	input  wire logic             done,
	output var  logic [CNT_W-1:0] count,
	output var  logic             below_limit
);

	logic [CNT_W-1:0] count_reg;
	logic [CNT_W-1:0] count_next;

	always_comb
	begin
		count_next = count_reg;
		if (done && (count_reg < LIMIT[CNT_W-1:0]))                       // [R7]
			count_next = count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
	end

	always_ff @(posedge clock)
	begin
		if (!reset_n)
			count_reg <= `BVR_CNT_RESET;                                    // [R6]
		else
			count_reg <= count_next;
	end

	assign count       = count_reg;
	assign below_limit = (count_reg < LIMIT[CNT_W-1:0]);                 // [R7]

endmodule

`default_nettype wire

// >>> bvr_remap_checker.sv
// Port checker for the boot vector remap
`timescale 1ns/1ps
`default_nettype none
module bvr_remap_checker
	import bvr_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire bvr_req_t    cpu_req,
	input  wire logic [31:0] cpu_wdata,
	input  wire bvr_out_t    mem_out,
	input  wire logic [31:0] mem_wdata_be,
	input  wire logic        remap_active,
	input  wire logic [1:0]  access_count
);
default clocking cb @(posedge clock); endclocking
default disable iff (!reset_n);
a_flash_decode: assert property
	(mem_out.flash_sel == (mem_out.valid && &mem_out.addr[31:21])) else $error("bad select");
a_remap_invert: assert property
	(cpu_req.valid && remap_active |=> mem_out.addr == ($past(cpu_req.addr) ^ 32'h0010_0000))
	else $error("no inversion");
a_addr_pass: assert property
	(cpu_req.valid && !remap_active |=> mem_out.addr == $past(cpu_req.addr)) else $error("bad pass");
a_byte_swap: assert property
	(reset_n |=> mem_wdata_be == {$past(cpu_wdata[7:0]), $past(cpu_wdata[15:8]),
	$past(cpu_wdata[23:16]), $past(cpu_wdata[31:24])}) else $error("bad byte order");
a_rearm_reset: assert property
	($rose(reset_n) |-> remap_active && access_count == 2'h0) else $error("not re-armed");
a_count_step: assert property
	(cpu_req.valid && cpu_req.done && access_count != 2'h2 |=> access_count == $past(access_count) + 2'h1
	&& remap_active == (access_count != 2'h2)) else $error("bad count");
cover property (remap_active ##1 !remap_active);
cover property (mem_out.flash_sel);
cover property ($rose(reset_n));
endmodule
`default_nettype wire

// >>> bvr_cpu_model.sv
// Processor side model issuing local memory accesses
`timescale 1ns/1ps
`default_nettype none
module bvr_cpu_model
	import bvr_pkg::*;
(
	input  wire logic        clock,
	output var  bvr_req_t    req,
	output var  logic [31:0] wdata
);
initial
begin
	req = '0;
	wdata = '0;
end
// One access held for one cycle; released lines show inverted values
task automatic access(input logic [31:0] a, input logic [31:0] d, input logic dn);
	@(negedge clock);
	req = '{valid: 1'b1, done: dn, addr: a};
	wdata = d;
	@(negedge clock);
	req = '{valid: 1'b0, done: 1'b0, addr: ~a};
	wdata = ~d;
endtask
endmodule
`default_nettype wire

// >>> tb_bvr_remap.sv
// Testbench for the boot vector remap
`timescale 1ns/1ps
`default_nettype none
module tb_bvr_remap
	import bvr_pkg::*;
;
logic        clock;
logic        reset_n;
bvr_req_t    req;
logic [31:0] wd;
bvr_out_t    mo;
logic [31:0] wbe;
logic        ract;
logic [1:0]  cnt;
int          bad_count;
int          samples_checked;
bvr_remap u_dut (.clock(clock), .reset_n(reset_n), .cpu_req(req), .cpu_wdata(wd),
	.mem_out(mo), .mem_wdata_be(wbe), .remap_active(ract), .access_count(cnt));
bvr_cpu_model u_cpu (.clock(clock), .req(req), .wdata(wd));
initial
begin
	clock = 1'b0;
	forever #20 clock = ~clock;
end
task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
	samples_checked++;
	if (g !== e)
	begin
		bad_count++;
		$display("mismatch %s expected %h seen %h", n, e, g);
	end
endtask
task automatic give_verdict();
	if (bad_count == 0 && samples_checked > 0)
		$display("ALL CHECKS OK");
	else
		$display("CHECKS NOT OK");
	$finish;
endtask
task automatic hard_reset();
	reset_n = 1'b0;
	repeat (20) @(negedge clock);
	reset_n = 1'b1;
endtask
task automatic fetch(input logic [31:0] a, input logic [31:0] e, input logic dn, input logic s);
	u_cpu.access(a, 32'hA1B2_C3D4, dn);
	check("addr", e, mo.addr);
	check("sel", 32'(s), 32'(mo.flash_sel));
	check("valid", 32'h1, 32'(mo.valid));
	check("wdata", 32'hD4C3_B2A1, wbe);
endtask
task automatic scen_boot();
	fetch(32'hFFF0_0100, 32'hFFE0_0100, 1'b1, 1'b1);
	fetch(32'hFFF0_0100, 32'hFFE0_0100, 1'b1, 1'b1);
	check("count", 32'h2, 32'(cnt));
	fetch(32'hFFF0_0100, 32'hFFF0_0100, 1'b1, 1'b1);
	check("count", 32'h2, 32'(cnt));
	@(negedge clock);
	check("idle", 32'h0, 32'(mo.valid));
endtask
task automatic scen_rearm();
	hard_reset();
	check("rearm", 32'h1, 32'(ract));
	fetch(32'h0000_1000, 32'h0010_1000, 1'b0, 1'b0);
	check("count", 32'h0, 32'(cnt));
	fetch(32'hFFC0_0000, 32'hFFD0_0000, 1'b1, 1'b0);
	fetch(32'hFFEF_FFFF, 32'hFFFF_FFFF, 1'b1, 1'b1);
	check("active", 32'h0, 32'(ract));
endtask
initial
begin
	bad_count = 0;
	samples_checked = 0;
	hard_reset();
	scen_boot();
	scen_rearm();
	give_verdict();
end
endmodule
bind bvr_remap bvr_remap_checker u_chk (.clock(clock), .reset_n(reset_n), .cpu_req(cpu_req),
	.cpu_wdata(cpu_wdata), .mem_out(mem_out), .mem_wdata_be(mem_wdata_be),
	.remap_active(remap_active), .access_count(access_count));
`default_nettype wire
